// *** hdl/shp_pkg.sv ***
`default_nettype none
package shp_pkg;
  localparam int SHP_CLK_HZ = 100_000_000;
  localparam int SHP_BAUD_MAX = 9600;
  // Divider for the fastest rate; the five slower rates are powers of two below it.
  localparam int SHP_BASE_DIV = SHP_CLK_HZ / SHP_BAUD_MAX;
  localparam int SHP_DIV_W = 20;
  localparam int SHP_RX_DEPTH = 100;
  localparam logic [2:0] SHP_BAUD_SEL_MAX = 3'h5;
  localparam logic [3:0] SHP_FRAME_LAST = 4'hA;
  localparam logic [3:0] SHP_STOP_FIRST = 4'h9;

  localparam logic [7:0] SHP_ADDR_CTRL = 8'h00;
  localparam logic [7:0] SHP_ADDR_STAT = 8'h04;
  localparam logic [7:0] SHP_ADDR_RXD = 8'h08;
  localparam logic [7:0] SHP_ADDR_TXD = 8'h0C;
  localparam logic [7:0] SHP_ADDR_CMD = 8'h10;
  localparam logic [1:0] SHP_RESP_OKAY = 2'h0;
  localparam logic [1:0] SHP_RESP_SLVERR = 2'h2;

  localparam int SHP_CTRL_PAR_EN = 0;
  localparam int SHP_CTRL_ODD = 1;
  localparam int SHP_CTRL_BAUD = 2;
  localparam int SHP_CTRL_SER = 5;
  localparam logic [5:0] SHP_CTRL_RESET = 6'h34;

  localparam int SHP_CMD_TALK = 0;
  localparam int SHP_CMD_REPLY_END = 1;
  localparam int SHP_CMD_LOCAL = 2;
  localparam int SHP_CMD_REMOTE = 3;
  localparam int SHP_CMD_LOCKOUT = 4;

  localparam int SHP_ST_ABORT = 0;
  localparam int SHP_ST_OVERRUN = 1;
  localparam int SHP_ST_PARERR = 2;
  localparam int SHP_ST_FRAMEERR = 3;
  localparam int SHP_ST_DTR = 4;
  localparam int SHP_ST_DSR = 5;
  localparam int SHP_ST_TALK = 6;
  localparam int SHP_ST_TXFULL = 7;
  localparam int SHP_ST_MODE = 8;
  localparam int SHP_ST_COUNT = 16;
  localparam int SHP_RXD_VALID = 8;

  localparam logic [7:0] SHP_CHAR_CTRL_C = 8'h03;
  localparam logic [7:0] SHP_CHAR_CR = 8'h0D;
  localparam logic [7:0] SHP_CHAR_LF = 8'h0A;

  typedef enum logic [1:0] {
    SHP_LOCAL = 2'b00,
    SHP_REMOTE = 2'b01,
    SHP_LOCKOUT = 2'b10
  } shp_mode_type;

  typedef enum logic [1:0] {
    SHP_RP_IDLE = 2'b00,
    SHP_RP_CR = 2'b01,
    SHP_RP_LF = 2'b10,
    SHP_RP_DRAIN = 2'b11
  } shp_reply_type;

  function automatic logic shp_parity(input logic [6:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction

  // Codes above the top rate select the top rate.
  function automatic logic [SHP_DIV_W-1:0] shp_bit_div(input int base, input logic [2:0] sel);
    logic [2:0] s;
    s = (sel > SHP_BAUD_SEL_MAX) ? SHP_BAUD_SEL_MAX : sel;
    return SHP_DIV_W'(base) << (SHP_BAUD_SEL_MAX - s);
  endfunction
endpackage
`default_nettype wire

// *** hdl/shp_char_if.sv ***
`default_nettype none
interface shp_char_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** hdl/shp_tx.sv ***
`default_nettype none
module shp_tx import shp_pkg::*; (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [SHP_DIV_W-1:0] div_in,
  input wire logic par_en_in,
  input wire logic odd_in,
  shp_char_if.snk ch,
  output logic txd_out,
  output logic busy_out
);
  logic busy_r;
  logic txd_r;
  logic [10:0] shift_r;
  logic [3:0] idx_r;
  logic [SHP_DIV_W-1:0] cnt_r;
  logic take;
  logic bit_end;
  logic slot;

  assign ch.ready = !busy_r;
  assign take = ch.valid && !busy_r;
  assign bit_end = busy_r && (cnt_r == div_in - 1'b1);
  assign slot = par_en_in ? shp_parity(ch.data[6:0], odd_in) : ch.data[7];
  assign txd_out = txd_r;
  assign busy_out = busy_r;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      busy_r <= 1'b0;
      txd_r <= 1'b1;
      shift_r <= '1;
      idx_r <= '0;
      cnt_r <= '0;
    end
    else if (take)
    begin
      busy_r <= 1'b1;
      shift_r <= {2'b11, slot, ch.data[6:0], 1'b0};
      txd_r <= 1'b0;
      idx_r <= '0;
      cnt_r <= '0;
    end
    else if (bit_end)
    begin
      cnt_r <= '0;
      shift_r <= {1'b1, shift_r[10:1]};
      txd_r <= (idx_r == SHP_FRAME_LAST) ? 1'b1 : shift_r[1];
      busy_r <= (idx_r != SHP_FRAME_LAST);
      idx_r <= idx_r + 4'h1;
    end
    else if (busy_r)
    begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_start_bit_low: assert property ($rose(busy_r) |-> !txd_out)
    else $error("start bit not low");
  a_stop_bits_high: assert property (busy_r && idx_r >= SHP_STOP_FIRST |-> txd_out)
    else $error("stop bit not high");
endmodule // shp_tx
`default_nettype wire

// *** hdl/shp_rx.sv ***
`default_nettype none
module shp_rx import shp_pkg::*; (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [SHP_DIV_W-1:0] div_in,
  input wire logic par_en_in,
  input wire logic odd_in,
  input wire logic rxd_in,
  shp_char_if.src ch,
  output logic par_err_out,
  output logic frame_err_out
);
  logic busy_r;
  logic [3:0] idx_r;
  logic [SHP_DIV_W-1:0] cnt_r;
  logic [9:0] sh_r;
  logic [9:0] sh_nxt;
  logic valid_r;
  logic [7:0] data_r;
  logic perr_r;
  logic ferr_r;
  logic sample;
  logic done;

  // Bits are sampled at mid-cell; the frame ends at the middle of the second stop bit.
  assign sample = busy_r && (cnt_r == '0);
  assign sh_nxt = {rxd_in, sh_r[9:1]};
  assign done = sample && (idx_r == SHP_FRAME_LAST);
  assign ch.valid = valid_r;
  assign ch.data = data_r;
  assign par_err_out = perr_r;
  assign frame_err_out = ferr_r;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      busy_r <= 1'b0;
      idx_r <= '0;
      cnt_r <= '0;
      sh_r <= '0;
      valid_r <= 1'b0;
      data_r <= '0;
      perr_r <= 1'b0;
      ferr_r <= 1'b0;
    end
    else
    begin
      valid_r <= done;
      perr_r <= done && par_en_in && (shp_parity(sh_nxt[6:0], odd_in) != sh_nxt[7]);
      ferr_r <= done && (sh_nxt[9:8] != 2'b11);
      if (done)
      begin
        data_r <= par_en_in ? {1'b0, sh_nxt[6:0]} : sh_nxt[7:0];
      end
      if (!busy_r)
      begin
        busy_r <= !rxd_in;
        cnt_r <= div_in >> 1;
        idx_r <= '0;
      end
      else if (sample)
      begin
        cnt_r <= div_in - 1'b1;
        idx_r <= idx_r + 4'h1;
        if (idx_r != '0)
        begin
          sh_r <= sh_nxt;
        end
        busy_r <= !(done || (idx_r == '0 && rxd_in));
      end
      else
      begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // shp_rx
`default_nettype wire

// *** hdl/shp_port.sv ***
// Functional notes
// - Each character takes eleven bit times, opening with one start bit.
// - Format of seven data bits plus even or odd parity.
// - Format of eight data bits, no parity.
// - One start and two stop bits always, not configurable.
// - Rate is 300, 600, 1200, 2400, 4800 or 9600 baud on both ends.
// - Terminal-ready output high means the host may send.
// - Terminal-ready low while receive buffer full, about one hundred characters.
// - Terminal-ready low from query until its reply has been sent.
// - Sample set-ready before each character; suspend output while it is false.
// - Terminal-ready stays low while output is suspended.
// - Control-C aborts the operation and discards pending output.
// - Every reply ends with carriage return then newline.
// - Selecting the serial port disables the parallel bus interface.
// - Go-local command enables all front panel keys.
// - Go-remote command disables all keys except the local key.
// - Remote-lockout command disables all keys including the local key.
// - Local, remote and lockout commands are accepted only on the serial port.
//
// The AXI4-Lite register port and the address map were decided locally.
`default_nettype none
module shp_port import shp_pkg::*; #(
  parameter int BASE_DIV = SHP_BASE_DIV,
  parameter int RX_DEPTH = SHP_RX_DEPTH
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [7:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  input wire logic rxd_in,
  output logic txd_out,
  output logic dtr_out,
  input wire logic dsr_in,
  output logic gpib_disable_out,
  output logic remote_out,
  output logic keys_enable_out,
  output logic local_key_enable_out
);
  localparam int PW = $clog2(RX_DEPTH);
  localparam int CW = $clog2(RX_DEPTH + 1);

  logic [5:0] ctrl_r;
  shp_mode_type mode_r;
  shp_reply_type reply_r;
  logic talk_r;
  logic [7:0] hold_r;
  logic hold_valid_r;
  logic abort_r, ovr_r, perr_r, ferr_r;
  logic [7:0] rx_mem_r [RX_DEPTH];
  logic [PW-1:0] wr_ptr_r, rd_ptr_r;
  logic [CW-1:0] count_r;
  logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic wlane0_r;
  logic [1:0] bresp_r, rresp_r;

  shp_char_if tx_if ();
  shp_char_if rx_if ();

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    return (p == PW'(RX_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    return a == SHP_ADDR_CTRL || a == SHP_ADDR_STAT || a == SHP_ADDR_RXD ||
      a == SHP_ADDR_TXD || a == SHP_ADDR_CMD;
  endfunction

  // Bus slave: address and data are latched independently, then acted on together.
  logic wr_fire, ar_fire, wr_ok;
  logic wr_ctrl, wr_stat, wr_txd, wr_cmd;
  assign s_axi_awready_out = !aw_hold_r && !bvalid_r;
  assign s_axi_wready_out = !w_hold_r && !bvalid_r;
  assign s_axi_arready_out = !rvalid_r;
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bresp_r;
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rdata_out = rdata_r;
  assign s_axi_rresp_out = rresp_r;
  assign wr_fire = aw_hold_r && w_hold_r;
  assign ar_fire = s_axi_arvalid_in && !rvalid_r;
  assign wr_ok = wr_fire && wlane0_r;
  assign wr_ctrl = wr_ok && awaddr_r == SHP_ADDR_CTRL;
  assign wr_stat = wr_ok && awaddr_r == SHP_ADDR_STAT;
  assign wr_txd = wr_ok && awaddr_r == SHP_ADDR_TXD;
  assign wr_cmd = wr_ok && awaddr_r == SHP_ADDR_CMD;

  // Serial link.
  logic ser, is_ctrl_c, rx_full, rx_empty, push, pop;
  logic out_valid, suspend, take;
  logic [SHP_DIV_W-1:0] bit_div;
  logic tx_busy, rx_perr, rx_ferr;
  logic cmd_local, cmd_remote, cmd_lockout;
  assign ser = ctrl_r[SHP_CTRL_SER];
  assign bit_div = shp_bit_div(BASE_DIV, ctrl_r[SHP_CTRL_BAUD +: 3]);
  assign rx_if.ready = 1'b1;
  assign is_ctrl_c = rx_if.valid && rx_if.data == SHP_CHAR_CTRL_C;
  assign rx_full = count_r == CW'(RX_DEPTH);
  assign rx_empty = count_r == '0;
  assign push = rx_if.valid && !is_ctrl_c && !rx_full;
  assign pop = ar_fire && s_axi_araddr_in == SHP_ADDR_RXD && !rx_empty;
  assign out_valid = hold_valid_r || (reply_r == SHP_RP_CR) || (reply_r == SHP_RP_LF);
  assign tx_if.valid = out_valid && dsr_in;
  assign tx_if.data = hold_valid_r ? hold_r :
    (reply_r == SHP_RP_CR) ? SHP_CHAR_CR : SHP_CHAR_LF;
  assign take = tx_if.valid && tx_if.ready;
  assign suspend = out_valid && !dsr_in;
  assign dtr_out = !rx_full && !talk_r && !suspend;
  assign cmd_local = wr_cmd && ser && wdata_r[SHP_CMD_LOCAL];
  assign cmd_remote = wr_cmd && ser && wdata_r[SHP_CMD_REMOTE];
  assign cmd_lockout = wr_cmd && ser && wdata_r[SHP_CMD_LOCKOUT];
  assign gpib_disable_out = ser;
  assign remote_out = mode_r != SHP_LOCAL;
  assign keys_enable_out = mode_r == SHP_LOCAL;
  assign local_key_enable_out = mode_r != SHP_LOCKOUT;

  logic [31:0] stat_word, rd_word;
  assign stat_word = (32'(count_r) << SHP_ST_COUNT) | (32'(mode_r) << SHP_ST_MODE) |
    (32'(hold_valid_r) << SHP_ST_TXFULL) | (32'(talk_r) << SHP_ST_TALK) |
    (32'(dsr_in) << SHP_ST_DSR) | (32'(dtr_out) << SHP_ST_DTR) |
    (32'(ferr_r) << SHP_ST_FRAMEERR) | (32'(perr_r) << SHP_ST_PARERR) |
    (32'(ovr_r) << SHP_ST_OVERRUN) | (32'(abort_r) << SHP_ST_ABORT);
  assign rd_word = (s_axi_araddr_in == SHP_ADDR_CTRL) ? 32'(ctrl_r) :
    (s_axi_araddr_in == SHP_ADDR_STAT) ? stat_word :
    (s_axi_araddr_in == SHP_ADDR_RXD) ?
      ((32'(!rx_empty) << SHP_RXD_VALID) | 32'(rx_mem_r[rd_ptr_r])) :
    (s_axi_araddr_in == SHP_ADDR_TXD) ? 32'(hold_r) : 32'h0000_0000;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wlane0_r <= 1'b0;
      bresp_r <= SHP_RESP_OKAY;
      rresp_r <= SHP_RESP_OKAY;
      rdata_r <= '0;
    end
    else
    begin
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr_in;
      end
      else if (wr_fire)
      begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata_in;
        wlane0_r <= s_axi_wstrb_in[0];
      end
      else if (wr_fire)
      begin
        w_hold_r <= 1'b0;
      end
      if (wr_fire)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= addr_mapped(awaddr_r) ? SHP_RESP_OKAY : SHP_RESP_SLVERR;
      end
      else if (s_axi_bready_in)
      begin
        bvalid_r <= 1'b0;
      end
      if (ar_fire)
      begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_word;
        rresp_r <= addr_mapped(s_axi_araddr_in) ? SHP_RESP_OKAY : SHP_RESP_SLVERR;
      end
      else if (s_axi_rready_in)
      begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // Receive buffer; control-C bypasses it so it is seen even when the buffer is full.
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
      begin
        rx_mem_r[wr_ptr_r] <= rx_if.data;
        wr_ptr_r <= ptr_inc(wr_ptr_r);
      end
      if (pop)
      begin
        rd_ptr_r <= ptr_inc(rd_ptr_r);
      end
      count_r <= count_r + CW'(push) - CW'(pop);
    end
  end

  // Sticky flags: a new event wins over a write-one clear in the same cycle.
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      abort_r <= 1'b0;
      ovr_r <= 1'b0;
      perr_r <= 1'b0;
      ferr_r <= 1'b0;
      ctrl_r <= SHP_CTRL_RESET;
      mode_r <= SHP_LOCAL;
    end
    else
    begin
      abort_r <= is_ctrl_c || (abort_r && !(wr_stat && wdata_r[SHP_ST_ABORT]));
      ovr_r <= (push == 1'b0 && rx_if.valid && !is_ctrl_c) ||
        (ovr_r && !(wr_stat && wdata_r[SHP_ST_OVERRUN]));
      perr_r <= rx_perr || (perr_r && !(wr_stat && wdata_r[SHP_ST_PARERR]));
      ferr_r <= rx_ferr || (ferr_r && !(wr_stat && wdata_r[SHP_ST_FRAMEERR]));
      if (wr_ctrl)
      begin
        ctrl_r <= wdata_r[5:0];
      end
      if (cmd_lockout)
      begin
        mode_r <= SHP_LOCKOUT;
      end
      else if (cmd_remote)
      begin
        mode_r <= SHP_REMOTE;
      end
      else if (cmd_local)
      begin
        mode_r <= SHP_LOCAL;
      end
    end
  end

  // Reply path: queued characters first, then the closing CR LF, then wait for the line.
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      talk_r <= 1'b0;
      hold_r <= '0;
      hold_valid_r <= 1'b0;
      reply_r <= SHP_RP_IDLE;
    end
    else if (is_ctrl_c)
    begin
      talk_r <= 1'b0;
      hold_valid_r <= 1'b0;
      reply_r <= SHP_RP_IDLE;
    end
    else
    begin
      if (take && hold_valid_r)
      begin
        hold_valid_r <= 1'b0;
      end
      else if (wr_txd && !hold_valid_r)
      begin
        hold_r <= wdata_r[7:0];
        hold_valid_r <= 1'b1;
      end
      if (wr_cmd && wdata_r[SHP_CMD_TALK])
      begin
        talk_r <= 1'b1;
      end
      case (reply_r)
        SHP_RP_IDLE:
          if (wr_cmd && wdata_r[SHP_CMD_REPLY_END])
          begin
            reply_r <= SHP_RP_CR;
          end
        SHP_RP_CR:
          if (take && !hold_valid_r)
          begin
            reply_r <= SHP_RP_LF;
          end
        SHP_RP_LF:
          if (take && !hold_valid_r)
          begin
            reply_r <= SHP_RP_DRAIN;
          end
        SHP_RP_DRAIN:
          if (!tx_busy)
          begin
            reply_r <= SHP_RP_IDLE;
            talk_r <= 1'b0;
          end
        default:
          reply_r <= SHP_RP_IDLE;
      endcase
    end
  end

  shp_tx u_tx (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .div_in(bit_div),
    .par_en_in(ctrl_r[SHP_CTRL_PAR_EN]),
    .odd_in(ctrl_r[SHP_CTRL_ODD]),
    .ch(tx_if.snk),
    .txd_out(txd_out),
    .busy_out(tx_busy)
  );

  shp_rx u_rx (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .div_in(bit_div),
    .par_en_in(ctrl_r[SHP_CTRL_PAR_EN]),
    .odd_in(ctrl_r[SHP_CTRL_ODD]),
    .rxd_in(rxd_in),
    .ch(rx_if.src),
    .par_err_out(rx_perr),
    .frame_err_out(rx_ferr)
  );

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_dtr_buf_full: assert property (rx_full |-> !dtr_out)
    else $error("terminal-ready high with full buffer");
  a_dtr_talk_hold: assert property ($rose(talk_r) |-> !dtr_out [*2])
    else $error("terminal-ready high while reply pending");
  a_dtr_idle_high: assert property (rx_empty && !talk_r && !hold_valid_r &&
    reply_r == SHP_RP_IDLE |-> dtr_out)
    else $error("terminal-ready low with nothing holding it");
  a_tx_needs_dsr: assert property ($rose(tx_busy) |-> $past(dsr_in))
    else $error("character started while set-ready false");
  a_suspend_dtr_low: assert property (hold_valid_r && !dsr_in |-> !dtr_out)
    else $error("terminal-ready high while suspended");
  a_ctrl_c_flush: assert property (is_ctrl_c |=> !hold_valid_r && !talk_r &&
    reply_r == SHP_RP_IDLE && abort_r)
    else $error("control-C did not discard output");
  a_reply_cr_lf: assert property (take && !hold_valid_r && !is_ctrl_c && reply_r == SHP_RP_CR |->
    tx_if.data == SHP_CHAR_CR ##1 reply_r == SHP_RP_LF)
    else $error("reply terminator out of order");
  a_cmd_serial_only: assert property (wr_cmd && !ser |=> $stable(mode_r))
    else $error("mode changed with serial port deselected");
  a_lockout_keys: assert property (cmd_lockout |=> !keys_enable_out && !local_key_enable_out)
    else $error("keys enabled after lockout");

  c_ctrl_c_seen: cover property (is_ctrl_c && out_valid);
  c_reply_done: cover property (reply_r == SHP_RP_DRAIN ##1 !talk_r);
  c_suspend: cover property (suspend [*3]);
  c_buffer_full: cover property (rx_full);
endmodule // shp_port
`default_nettype wire

// *** dv/shp_host_model.sv ***
`default_nettype none
module shp_host_model (
  input wire logic clk_in,
  input wire logic [19:0] div_in,
  input wire logic txd_in,
  input wire logic dtr_in,
  output logic rxd_out,
  output logic dsr_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] frames[$];
  int stalls = 0;
  initial
  begin
    rxd_out = 1'b1;
    dsr_out = 1'b1;
  end
  function automatic logic [10:0] frm(input logic [7:0] c, input logic pe, input logic od);
    return {2'b11, pe ? ^{c[6:0], od} : c[7], c[6:0], 1'b0};
  endfunction
  task automatic set_dsr(input logic v);
    @(posedge clk_in);
    dsr_out <= v;
  endtask
  // Waits while held off, unless set-ready was dropped so that control-C gets through.
  task automatic send(input logic [7:0] c, input logic pe, input logic od);
    logic [10:0] f;
    f = frm(c, pe, od);
    for (int n = 0; n < 9000 && !dtr_in && dsr_out; n++) @(posedge clk_in);
    if (!dtr_in && dsr_out) stalls++;
    for (int i = 0; i < 11; i++)
    begin
      @(posedge clk_in);
      rxd_out <= f[i];
      repeat (div_in - 1) @(posedge clk_in);
    end
  endtask
  always
  begin : rx
    logic [10:0] f;
    @(negedge txd_in);
    repeat (div_in / 2) @(posedge clk_in);
    for (int i = 0; i < 11; i++)
    begin
      f[i] = txd_in;
      if (i < 10) repeat (div_in) @(posedge clk_in);
    end
    frames.push_back(f);
  end
endmodule // shp_host_model
`default_nettype wire

// *** dv/shp_port_tb_top.sv ***
`default_nettype none
module shp_port_tb_top import shp_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BD = 16;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic br = 1'b0;
  logic arv = 1'b0;
  logic rr = 1'b0;
  logic [7:0] aw_a = 8'h00;
  logic [7:0] ar_a = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [19:0] div = 20'(BD);
  logic [3:0] ws = 4'hF;
  logic awr, wrdy, bv, arr, rv, rxd, txd, dtr, dsr, gpib, remote, keys, lkey;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, v;
  int failures = 0;
  int n_checks = 0;
  always #5 clk_in = ~clk_in;
  shp_port #(.BASE_DIV(BD), .RX_DEPTH(4)) i_shp_port (.clk_in(clk_in), .reset_in(reset_in),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(aw_a),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy), .s_axi_wdata_in(wd),
    .s_axi_wstrb_in(ws), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
    .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_araddr_in(ar_a), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .rxd_in(rxd), .txd_out(txd),
    .dtr_out(dtr), .dsr_in(dsr), .gpib_disable_out(gpib), .remote_out(remote),
    .keys_enable_out(keys), .local_key_enable_out(lkey));
  shp_host_model i_shp_host_model (.clk_in(clk_in), .div_in(div), .txd_in(txd),
    .dtr_in(dtr), .rxd_out(rxd), .dsr_out(dsr));
  task automatic report_and_stop();
    if (failures == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge clk_in);
    awv <= 1'b1;
    aw_a <= a;
    wv <= 1'b1;
    wd <= d;
    br <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(negedge clk_in);
      ta = awv & awr;
      tw = wv & wrdy;
      tb = bv;
      resp = bresp;
      @(posedge clk_in);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb)
      begin
        br <= 1'b0;
        return;
      end
    end
    failures++;
    report_and_stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic ta, tb;
    @(posedge clk_in);
    arv <= 1'b1;
    ar_a <= a;
    rr <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(negedge clk_in);
      ta = arv & arr;
      tb = rv;
      d = rdata;
      resp = rresp;
      @(posedge clk_in);
      if (ta) arv <= 1'b0;
      if (tb)
      begin
        rr <= 1'b0;
        return;
      end
    end
    failures++;
    report_and_stop();
  endtask
  task automatic get_frame(input logic [7:0] c, input logic pe, input logic od);
    for (int n = 0; n < 9000 && i_shp_host_model.frames.size() == 0; n++) @(posedge clk_in);
    if (i_shp_host_model.frames.size() == 0)
    begin
      failures++;
      report_and_stop();
    end
    chk("frame", i_shp_host_model.frm(c, pe, od), i_shp_host_model.frames.pop_front());
  endtask
  // Terminal-ready is read at the falling edge, where it has settled.
  task automatic pin(input string nm, input logic e);
    @(negedge clk_in);
    chk(nm, e, dtr);
  endtask
  initial
  begin
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
    pin("dtr", 1'b1);
    chk("gpib_off", 1, gpib);
    rd(SHP_ADDR_CTRL, v);
    chk("ctrl", 6'h34, v[5:0]);
    for (int s = 0; s <= 5; s++)
    begin
      div <= 20'(BD) << (5 - s);
      wr(SHP_ADDR_CTRL, 32'h20 | (s << 2));
      wr(SHP_ADDR_TXD, 32'h80 | s);
      get_frame(8'h80 | s, 1'b0, 1'b0);
      i_shp_host_model.send(8'hC0 | s, 1'b0, 1'b0);
      rd(SHP_ADDR_RXD, v);
      chk("rxd", 32'h1C0 | s, v);
    end
    for (int od = 0; od < 2; od++)
    begin
      wr(SHP_ADDR_CTRL, 32'h35 | (od << 1));
      wr(SHP_ADDR_TXD, 32'hB5);
      get_frame(8'hB5, 1'b1, od[0]);
      i_shp_host_model.send(8'h35, 1'b1, od[0]);
      rd(SHP_ADDR_RXD, v);
      chk("rxd_par", 32'h135, v);
    end
    wr(SHP_ADDR_CTRL, 32'h34);
    for (int k = 0; k < 4; k++) i_shp_host_model.send(8'h61 + k, 1'b0, 1'b0);
    pin("dtr_full", 1'b0);
    for (int k = 0; k < 4; k++)
    begin
      rd(SHP_ADDR_RXD, v);
      chk("rxd_buf", 32'h161 + k, v);
    end
    pin("dtr_room", 1'b1);
    i_shp_host_model.send(SHP_CHAR_LF, 1'b0, 1'b0);
    rd(SHP_ADDR_RXD, v);
    wr(SHP_ADDR_CMD, 32'h01);
    pin("dtr_talk", 1'b0);
    wr(SHP_ADDR_TXD, 32'h31);
    wr(SHP_ADDR_CMD, 32'h02);
    get_frame(8'h31, 1'b0, 1'b0);
    chk("dtr_reply", 0, dtr);
    get_frame(8'h0D, 1'b0, 1'b0);
    get_frame(8'h0A, 1'b0, 1'b0);
    for (int n = 0; n < 100 && !dtr; n++) @(posedge clk_in);
    pin("dtr_done", 1'b1);
    i_shp_host_model.set_dsr(1'b0);
    wr(SHP_ADDR_TXD, 32'h47);
    repeat (33 * BD) @(posedge clk_in);
    chk("tx_held", 0, i_shp_host_model.frames.size());
    pin("dtr_held", 1'b0);
    i_shp_host_model.set_dsr(1'b1);
    get_frame(8'h47, 1'b0, 1'b0);
    i_shp_host_model.set_dsr(1'b0);
    wr(SHP_ADDR_TXD, 32'h55);
    wr(SHP_ADDR_CMD, 32'h01);
    i_shp_host_model.send(SHP_CHAR_CTRL_C, 1'b0, 1'b0);
    rd(SHP_ADDR_STAT, v);
    chk("abort", 1, v[0]);
    pin("dtr_abort", 1'b1);
    i_shp_host_model.set_dsr(1'b1);
    repeat (400) @(posedge clk_in);
    chk("discard", 0, i_shp_host_model.frames.size());
    wr(SHP_ADDR_CMD, 32'h08);
    chk("mode_rem", 3'b101, {remote, keys, lkey});
    wr(SHP_ADDR_CMD, 32'h10);
    chk("mode_lock", 3'b100, {remote, keys, lkey});
    wr(SHP_ADDR_CMD, 32'h04);
    chk("mode_loc", 3'b011, {remote, keys, lkey});
    wr(SHP_ADDR_CTRL, 32'h14);
    wr(SHP_ADDR_CMD, 32'h08);
    chk("ser_only", 2'b00, {remote, gpib});
    rd(8'h20, v);
    chk("unmapped_rresp", SHP_RESP_SLVERR, resp);
    chk("unmapped_rdata", 0, v);
    ws <= 4'h0;
    wr(SHP_ADDR_CTRL, 32'h34);
    chk("wr_bresp", SHP_RESP_OKAY, resp);
    ws <= 4'hF;
    rd(SHP_ADDR_CTRL, v);
    chk("strb_ignored", 6'h14, v[5:0]);
    wr(8'h20, 32'h0);
    chk("unmapped_bresp", SHP_RESP_SLVERR, resp);
    chk("host_stall", 0, i_shp_host_model.stalls);
    report_and_stop();
  end
endmodule // shp_port_tb_top
`default_nettype wire
